// *** rtl/tcm_top.sv ***
// mode registers and count pulse selection of the three-channel timer
`timescale 1ns/10ps
`default_nettype none
module tcm_top
  import tcm_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // channel 2 overflow event
  input wire logic i_ch2_ovf,
  // channel 0
  output logic o_ch0_pulse,
  output logic o_ch0_clear,
  output logic o_ch0_running,
  output logic o_ch0_sel_ok,
  // channel 1
  output logic o_ch1_pulse,
  output logic o_ch1_clear,
  output logic o_ch1_running,
  output logic o_ch1_sel_ok,
  output logic o_ch1_mode_ok,
  output logic o_ch1_cascade,
  output logic o_ch1_carrier,
  // channel 2
  output logic [1:0] o_ch2_mode,
  output logic [2:0] o_ch2_sel,
  output logic o_ch2_clear,
  output logic o_ch2_enable
);

  tcm_top_st_t s_q;
  tcm_top_st_t s_d;

  // ***********************************************
  // write decode
  // ***********************************************
  logic wr_ch0;
  logic wr_ch1;
  logic wr_ch2;
  logic wr_rs;
  logic set_start0;
  logic set_start1;
  logic set_start2;

  // alias lets software restart without a read-modify-write
  assign wr_ch0 = i_wr && (i_addr == `TCM_OFS_CH0);
  assign wr_ch1 = i_wr && (i_addr == `TCM_OFS_CH1);
  assign wr_ch2 = i_wr && (i_addr == `TCM_OFS_CH2);
  assign wr_rs = i_wr && (i_addr == `TCM_OFS_RESTART);
  assign set_start0 = (wr_ch0 && i_wdata[`TCM_START]) ||
                      (wr_rs && i_wdata[`TCM_RS_CH0]);
  assign set_start1 = (wr_ch1 && i_wdata[`TCM_START]) ||
                      (wr_rs && i_wdata[`TCM_RS_CH1]);
  assign set_start2 = (wr_ch2 && i_wdata[`TCM_START]) ||
                      (wr_rs && i_wdata[`TCM_RS_CH2]);

  // ***********************************************
  // field views
  // ***********************************************
  logic [2:0] sel0;
  logic [2:0] sel1;
  logic [1:0] msel1;
  logic [1:0] msel2;

  assign sel0 = s_q.ch0[`TCM_SEL_HI:`TCM_SEL_LO];
  assign sel1 = s_q.ch1[`TCM_SEL_HI:`TCM_SEL_LO];
  assign msel1 = s_q.ch1[`TCM_MSEL_HI:`TCM_MSEL_LO];
  assign msel2 = s_q.ch2[`TCM_MSEL_HI:`TCM_MSEL_LO];

  // ***********************************************
  // count pulse selection
  // ***********************************************
  logic [3:0] tap0;
  logic [3:0] tap1;
  logic vld0;
  logic vld1;
  logic ovf1;

  // channel 0 source table
  always_comb begin
    tap0 = `TCM_TAP_NONE;
    vld0 = 1'b1;
    case (sel0)
      `TCM_SEL_4: tap0 = `TCM_TAP_10;
      `TCM_SEL_5: tap0 = `TCM_TAP_8;
      `TCM_SEL_6: tap0 = `TCM_TAP_6;
      `TCM_SEL_7: tap0 = `TCM_TAP_4;
      default: vld0 = 1'b0;
    endcase
  end

  // channel 1 source table, code 2 chains on channel 2
  always_comb begin
    tap1 = `TCM_TAP_NONE;
    vld1 = 1'b1;
    ovf1 = 1'b0;
    case (sel1)
      `TCM_SEL_OVF: ovf1 = 1'b1;
      `TCM_SEL_3: tap1 = `TCM_TAP_5;
      `TCM_SEL_4: tap1 = `TCM_TAP_12;
      `TCM_SEL_5: tap1 = `TCM_TAP_10;
      `TCM_SEL_6: tap1 = `TCM_TAP_8;
      `TCM_SEL_7: tap1 = `TCM_TAP_6;
      default: vld1 = 1'b0;
    endcase
  end

  // prescaler taps: a tap fires when its low bits are all ones, once per 2^k
  logic [DIV_W-1:0] mask0;
  logic [DIV_W-1:0] mask1;
  logic tick0;
  logic tick1;

  // a tap of DIV_W wraps the shift to zero, giving an all-ones mask
  assign mask0 = (DIV_W'(`TCM_DIV_ONE) << tap0) - DIV_W'(`TCM_DIV_ONE);
  assign mask1 = (DIV_W'(`TCM_DIV_ONE) << tap1) - DIV_W'(`TCM_DIV_ONE);
  assign tick0 = vld0 && ((s_q.div[DIV_W-1:0] & mask0) == mask0);
  assign tick1 = vld1 && (ovf1 ? i_ch2_ovf :
                 ((s_q.div[DIV_W-1:0] & mask1) == mask1));

  // ***********************************************
  // register next state
  // ***********************************************
  // start bits live for one cycle; a new write in that cycle still sets
  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + `TCM_DIV_ONE;
    s_d.ch0[`TCM_START] = 1'b0;
    s_d.ch1[`TCM_START] = 1'b0;
    s_d.ch2[`TCM_START] = 1'b0;
    if (wr_ch0) begin
      // low two bits are kept at zero whatever software writes
      s_d.ch0 = {i_wdata[`TCM_SEL_HI:`TCM_ENABLE], `TCM_LOW2};
    end
    if (wr_ch1) begin
      s_d.ch1 = i_wdata[`TCM_REG_W-1:0];
    end
    if (wr_ch2) begin
      s_d.ch2 = i_wdata[`TCM_REG_W-1:0];
    end
    if (set_start0) begin
      s_d.ch0[`TCM_START] = 1'b1;
    end
    if (set_start1) begin
      s_d.ch1[`TCM_START] = 1'b1;
    end
    if (set_start2) begin
      s_d.ch2[`TCM_START] = 1'b1;
    end
    // read data stand for one cycle only
    s_d.rdata = `TCM_RD_ZERO;
    if (i_rd) begin
      case (i_addr)
        `TCM_OFS_CH0: s_d.rdata = {1'b0, s_q.ch0};
        `TCM_OFS_CH1: s_d.rdata = {1'b0, s_q.ch1};
        `TCM_OFS_CH2: s_d.rdata = {1'b0, s_q.ch2};
        default: s_d.rdata = `TCM_RD_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.ch0 <= `TCM_MODE_RST;
      s_q.ch1 <= `TCM_MODE_RST;
      s_q.ch2 <= `TCM_MODE_RST;
      s_q.div <= '0;
      s_q.rdata <= `TCM_RD_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  // ***********************************************
  // channel sequencers
  // ***********************************************
  tcm_chan u_ch0 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick0),
    .i_start(s_q.ch0[`TCM_START]),
    .i_enable(s_q.ch0[`TCM_ENABLE]),
    .o_pulse(o_ch0_pulse),
    .o_clear(o_ch0_clear),
    .o_running(o_ch0_running)
  );

  tcm_chan u_ch1 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick1),
    .i_start(s_q.ch1[`TCM_START]),
    .i_enable(s_q.ch1[`TCM_ENABLE]),
    .o_pulse(o_ch1_pulse),
    .o_clear(o_ch1_clear),
    .o_running(o_ch1_running)
  );

  // ***********************************************
  // outputs
  // ***********************************************
  assign o_rdata = s_q.rdata;
  assign o_ch0_sel_ok = vld0;
  assign o_ch1_sel_ok = vld1;
  // prohibited mode codes are flagged, not repaired
  assign o_ch1_mode_ok = (msel1 == `TCM_MODE_8BIT) ||
                         (msel1 == `TCM_MODE_16BIT);
  assign o_ch1_cascade = (msel1 == `TCM_MODE_16BIT);
  assign o_ch1_carrier = (msel1 == `TCM_MODE_8BIT) &&
                         (msel2 == `TCM_MODE_CARRIER);
  assign o_ch2_mode = msel2;
  assign o_ch2_sel = s_q.ch2[`TCM_SEL_HI:`TCM_SEL_LO];
  assign o_ch2_clear = s_q.ch2[`TCM_START];
  assign o_ch2_enable = s_q.ch2[`TCM_ENABLE];

  // ***********************************************
  // checks
  // ***********************************************
  logic [3:0] cfg0;
  assign cfg0 = {sel0, s_q.ch0[`TCM_ENABLE]};

  AST_CH0_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_ch0_pulse |-> $past(vld0) && $past(tick0))
    else $error("channel 0 pulse without a valid divided source");

  AST_CH1_OVF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_ch1_pulse && ($past(sel1) == `TCM_SEL_OVF)) |-> $past(i_ch2_ovf))
    else $error("channel 1 pulse without channel 2 overflow");

  AST_CH0_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_start0 |-> ##2 o_ch0_clear)
    else $error("channel 0 start did not clear");

  AST_CH1_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_start1 |-> ##1 s_q.ch1[`TCM_START] ##1 (o_ch1_clear && o_ch1_running))
    else $error("channel 1 start did not clear and run");

  AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !s_q.ch0[`TCM_ENABLE] |=> !o_ch0_pulse)
    else $error("channel 0 counted while halted");

  AST_RST_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> (s_q.ch0 == `TCM_MODE_RST) && (s_q.ch1 == `TCM_MODE_RST))
    else $error("mode registers not cleared by reset");

  AST_PROHIB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !vld1 |=> !o_ch1_pulse)
    else $error("channel 1 pulse from prohibited code");

  AST_LOW_BITS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_ch0 |=> (s_q.ch0[`TCM_MSEL_HI:`TCM_MSEL_LO] == `TCM_LOW2))
    else $error("channel 0 low bits not zero");

  AST_MODE16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ch1 && (i_wdata[`TCM_MSEL_HI:`TCM_MSEL_LO] == `TCM_MODE_16BIT))
    |=> o_ch1_cascade && o_ch1_mode_ok)
    else $error("channel 1 16-bit mode not taken");

  AST_CARRIER: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ch2 && !wr_ch1 &&
     (i_wdata[`TCM_MSEL_HI:`TCM_MSEL_LO] == `TCM_MODE_CARRIER) &&
     (msel1 == `TCM_MODE_8BIT))
    |=> o_ch1_carrier)
    else $error("carrier pairing not flagged");

  AST_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_rs && i_wdata[`TCM_RS_CH0]) |=> s_q.ch0[`TCM_START] && (cfg0 == $past(cfg0)))
    else $error("restart changed channel 0 settings");

  AST_SELFCLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.ch1[`TCM_START] && !set_start1) |=> !s_q.ch1[`TCM_START])
    else $error("channel 1 start bit did not self-clear");

  AST_BIT7: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd |=> !o_rdata[`TCM_REG_W])
    else $error("bit 7 read as one");

  COV_CH0_PULSE: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    set_start0 ##[1:40] o_ch0_pulse);
  COV_CH1_OVF: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_ch1_pulse && ($past(sel1) == `TCM_SEL_OVF));
  COV_CARRIER: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ch1_carrier));
  COV_RESTART: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_rs ##2 o_ch1_clear);

endmodule // tcm_top
`default_nettype wire

// *** pkg/tcm_map.svh ***
// register map, field positions and codes of the timer mode control block
//
// Behaviour
// - channel 0 codes 4..7 pick clock/2^10,8,6,4
// - channel 1 code 2 ovf, 3..7 divided clocks
// - channel 0 start clears counter and flag
// - channel 1 start clears counter and flag
// - enable low holds count, high counts
// - reset clears channel 0 and 1 registers
// - prohibited pulse code gives no count pulse
// - channel 1 mode 00 8-bit, 10 16-bit
// - channel 1 8-bit pairs channel 2 carrier
// - start bit alone restarts with present settings
// - start bit self-clears, writable on its own
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

// ***********************************************
// register offsets
// ***********************************************
`define TCM_OFS_CH2 12'hF90
`define TCM_OFS_CH0 12'hFA0
`define TCM_OFS_CH1 12'hFA8
`define TCM_OFS_RESTART 12'hFB0

// ***********************************************
// field layout and reset values
// ***********************************************
`define TCM_REG_W 7
`define TCM_MODE_RST 7'h00
`define TCM_SEL_HI 6
`define TCM_SEL_LO 4
`define TCM_START 3
`define TCM_ENABLE 2
`define TCM_MSEL_HI 1
`define TCM_MSEL_LO 0
`define TCM_RS_CH0 0
`define TCM_RS_CH1 1
`define TCM_RS_CH2 2
`define TCM_RD_ZERO 8'h00
`define TCM_LOW2 2'h0

// ***********************************************
// count pulse codes and prescaler taps
// ***********************************************
`define TCM_SEL_OVF 3'h2
`define TCM_SEL_3 3'h3
`define TCM_SEL_4 3'h4
`define TCM_SEL_5 3'h5
`define TCM_SEL_6 3'h6
`define TCM_SEL_7 3'h7
`define TCM_TAP_4 4'h4
`define TCM_TAP_5 4'h5
`define TCM_TAP_6 4'h6
`define TCM_TAP_8 4'h8
`define TCM_TAP_10 4'hA
`define TCM_TAP_12 4'hC
`define TCM_TAP_NONE 4'h0
`define TCM_DIV_ONE 12'h001

// ***********************************************
// operation modes
// ***********************************************
`define TCM_MODE_8BIT 2'h0
`define TCM_MODE_16BIT 2'h2
`define TCM_MODE_CARRIER 2'h3

`endif

// *** pkg/tcm_pkg.sv ***
// types of the timer mode control block
`include "tcm_map.svh"
package tcm_pkg;

  // channel run state
  typedef enum logic {
    TCM_IDLE,
    TCM_RUN
  } tcm_run_t;

  // state of one channel sequencer
  typedef struct packed {
    tcm_run_t run;
    logic pulse;
    logic clear;
  } tcm_chan_st_t;

  // state of the mode register block
  typedef struct packed {
    logic [`TCM_REG_W-1:0] ch0;
    logic [`TCM_REG_W-1:0] ch1;
    logic [`TCM_REG_W-1:0] ch2;
    logic [11:0] div;
    logic [7:0] rdata;
  } tcm_top_st_t;

endpackage

// *** rtl/tcm_chan.sv ***
// one channel sequencer: start, run state and gated count pulse
`timescale 1ns/10ps
`default_nettype none
module tcm_chan
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_enable,
  // status
  output logic o_pulse,
  output logic o_clear,
  output logic o_running
);

  tcm_chan_st_t s_q;
  tcm_chan_st_t s_d;

  // ***********************************************
  // next state
  // ***********************************************
  // the start cycle itself gives no pulse so the cleared counter starts clean
  always_comb begin
    s_d = s_q;
    s_d.clear = i_start;
    case (s_q.run)
      TCM_IDLE: begin
        if (i_start) begin
          s_d.run = TCM_RUN;
        end
      end
      TCM_RUN: begin
        s_d.run = TCM_RUN;
      end
      default: begin
        s_d.run = TCM_IDLE;
      end
    endcase
    // enable low halts and holds the count
    s_d.pulse = (s_q.run == TCM_RUN) && !i_start && i_enable && i_tick;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{run: TCM_IDLE, pulse: 1'b0, clear: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pulse = s_q.pulse;
  assign o_clear = s_q.clear;
  assign o_running = (s_q.run == TCM_RUN);

endmodule // tcm_chan
`default_nettype wire

// *** tb/tb_tcm_top.sv ***
// self-checking bench of the timer mode control block
`timescale 1ns/10ps
`default_nettype none
`include "tcm_map.svh"
module tb_tcm_top import tcm_pkg::*;;

// ***********************************************
// compare helper
// ***********************************************
`define CHK(name, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("mismatch %s expected %0h seen %0h", name, exp, got); \
  end \
end

// ***********************************************
// stimulus and observed signals
// ***********************************************
logic i_clk = 1'b0;
logic i_rst_n = 1'b0;
logic [11:0] i_addr = 12'h000;
logic [7:0] i_wdata = 8'h00;
logic i_wr = 1'b0;
logic i_rd = 1'b0;
logic i_ch2_ovf = 1'b0;
logic [7:0] o_rdata;
logic o_ch0_pulse, o_ch0_clear, o_ch0_running, o_ch0_sel_ok;
logic o_ch1_pulse, o_ch1_clear, o_ch1_running, o_ch1_sel_ok;
logic o_ch1_mode_ok, o_ch1_cascade, o_ch1_carrier;
logic [1:0] o_ch2_mode;
logic [2:0] o_ch2_sel;
logic o_ch2_clear, o_ch2_enable;
int err_count = 0;
int n_checks = 0;
int cyc = 0;
int np0 = 0;
int np1 = 0;
int nc0 = 0;
int nc1 = 0;
int nc2 = 0;
int gap0 = 0;
int gap1 = 0;
int last0 = 0;
int last1 = 0;
int snap = 0;
// prescaler taps per divided-clock code, lowest divided-clock code first
int k0[4] = '{10, 8, 6, 4};
int k1[5] = '{5, 12, 10, 8, 6};

// 50 MHz clock
always #10 i_clk = ~i_clk;

tcm_top i_tcm_top (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ch2_ovf(i_ch2_ovf),
  .o_ch0_pulse(o_ch0_pulse), .o_ch0_clear(o_ch0_clear),
  .o_ch0_running(o_ch0_running), .o_ch0_sel_ok(o_ch0_sel_ok),
  .o_ch1_pulse(o_ch1_pulse), .o_ch1_clear(o_ch1_clear),
  .o_ch1_running(o_ch1_running), .o_ch1_sel_ok(o_ch1_sel_ok),
  .o_ch1_mode_ok(o_ch1_mode_ok), .o_ch1_cascade(o_ch1_cascade),
  .o_ch1_carrier(o_ch1_carrier), .o_ch2_mode(o_ch2_mode), .o_ch2_sel(o_ch2_sel),
  .o_ch2_clear(o_ch2_clear), .o_ch2_enable(o_ch2_enable)
);

// count one-cycle events on the falling edge, where registered outputs are settled
always @(negedge i_clk) begin
  cyc++;
  if (o_ch0_pulse === 1'b1) begin
    np0++;
    gap0 = cyc - last0;
    last0 = cyc;
  end
  if (o_ch1_pulse === 1'b1) begin
    np1++;
    gap1 = cyc - last1;
    last1 = cyc;
  end
  if (o_ch0_clear === 1'b1) nc0++;
  if (o_ch1_clear === 1'b1) nc1++;
  if (o_ch2_clear === 1'b1) nc2++;
end

// ***********************************************
// bus tasks
// ***********************************************
task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
  @(posedge i_clk);
  i_addr <= a;
  i_wdata <= d;
  i_wr <= 1'b1;
  @(posedge i_clk);
  i_wr <= 1'b0;
endtask

// read data stand only in the cycle after the strobe
task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
  @(posedge i_clk);
  i_addr <= a;
  i_rd <= 1'b1;
  @(posedge i_clk);
  i_rd <= 1'b0;
  @(negedge i_clk);
  `CHK("rdata", exp, o_rdata)
endtask

task automatic idle(input int n);
  repeat (n) @(negedge i_clk);
endtask

// reset is asynchronous, so it may drop anywhere; release on an edge
task automatic rst_seq(input int n);
  i_rst_n <= 1'b0;
  repeat (n) @(posedge i_clk);
  i_rst_n <= 1'b1;
endtask

task automatic end_sim;
  $display("checks %0d mismatches %0d", n_checks, err_count);
  if (err_count == 0 && n_checks > 0) begin
    $display("No errors found");
  end else begin
    $display("Errors were found");
  end
  $finish;
endtask

// watchdog: the longest run is some 16k cycles, so 60k means a hang
initial begin
  repeat (60000) @(posedge i_clk);
  err_count++;
  end_sim();
end

// ***********************************************
// test sequence
// ***********************************************
initial begin
  rst_seq(6);
  rd_chk(`TCM_OFS_CH0, 8'h00);
  rd_chk(`TCM_OFS_CH1, 8'h00);
  `CHK("ch0 running", 1'b0, o_ch0_running)
  // every code: only the documented ones give a count pulse source
  for (int c = 0; c < 8; c++) begin
    wr_reg(`TCM_OFS_CH0, 8'(c << 4));
    wr_reg(`TCM_OFS_CH1, 8'(c << 4));
    idle(2);
    `CHK("ch0 sel ok", (c >= 4), o_ch0_sel_ok)
    `CHK("ch1 sel ok", (c >= 2), o_ch1_sel_ok)
  end
  // upper bits all ones: bit 7 dropped, start self-clears; software keeps bits 1:0 zero
  snap = nc0;
  wr_reg(`TCM_OFS_CH0, 8'hFC);
  idle(5);
  `CHK("ch0 clear", snap + 1, nc0)
  `CHK("ch0 running", 1'b1, o_ch0_running)
  rd_chk(`TCM_OFS_CH0, 8'h74);
  // prohibited code with start and enable gives no pulse
  wr_reg(`TCM_OFS_CH0, 8'h0C);
  idle(3);
  snap = np0;
  idle(1100);
  `CHK("ch0 no pulse", snap, np0)
  // pulse spacing for each divided-clock code
  for (int c = 4; c < 8; c++) begin
    wr_reg(`TCM_OFS_CH0, 8'(c << 4) | 8'h0C);
    idle((2 << k0[c-4]) + 8);
    `CHK("ch0 period", (1 << k0[c-4]), gap0)
  end
  for (int c = 3; c < 8; c++) begin
    wr_reg(`TCM_OFS_CH1, 8'(c << 4) | 8'h0C);
    idle((2 << k1[c-3]) + 8);
    `CHK("ch1 period", (1 << k1[c-3]), gap1)
  end
  `CHK("ch1 running", 1'b1, o_ch1_running)
  // a running channel 1 switched to a prohibited code stops pulsing
  wr_reg(`TCM_OFS_CH1, 8'h0C);
  idle(3);
  snap = np1;
  idle(100);
  `CHK("ch1 no pulse", snap, np1)
  // enable low holds: no pulse, then a single-bit restart keeps the rest
  wr_reg(`TCM_OFS_CH0, 8'h70);
  idle(3);
  snap = np0;
  idle(100);
  `CHK("ch0 halted", snap, np0)
  snap = nc0;
  wr_reg(`TCM_OFS_RESTART, 8'h01);
  idle(5);
  `CHK("ch0 restart clear", snap + 1, nc0)
  rd_chk(`TCM_OFS_CH0, 8'h70);
  // channel 1 counts channel 2 overflows only
  snap = nc1;
  wr_reg(`TCM_OFS_CH1, 8'h2C);
  idle(5);
  `CHK("ch1 clear", snap + 1, nc1)
  snap = np1;
  idle(300);
  `CHK("ch1 no tick", snap, np1)
  @(posedge i_clk);
  i_ch2_ovf <= 1'b1;
  @(posedge i_clk);
  i_ch2_ovf <= 1'b0;
  idle(3);
  `CHK("ch1 ovf pulse", snap + 1, np1)
  snap = nc1;
  wr_reg(`TCM_OFS_RESTART, 8'h02);
  idle(5);
  `CHK("ch1 restart clear", snap + 1, nc1)
  rd_chk(`TCM_OFS_CH1, 8'h24);
  // channel 2 fields, then channel 1 modes beside carrier mode 11
  snap = nc2;
  wr_reg(`TCM_OFS_CH2, 8'h5F);
  idle(5);
  `CHK("ch2 clear", snap + 1, nc2)
  `CHK("ch2 sel", 3'h5, o_ch2_sel)
  `CHK("ch2 enable", 1'b1, o_ch2_enable)
  `CHK("ch2 mode", 2'h3, o_ch2_mode)
  rd_chk(`TCM_OFS_CH2, 8'h57);
  for (int m = 0; m < 4; m++) begin
    wr_reg(`TCM_OFS_CH1, 8'(m));
    idle(2);
    `CHK("ch1 mode ok", (m == 0 || m == 2), o_ch1_mode_ok)
    `CHK("ch1 cascade", (m == 2), o_ch1_cascade)
    `CHK("ch1 carrier", (m == 0), o_ch1_carrier)
  end
  wr_reg(`TCM_OFS_CH2, 8'h01);
  wr_reg(`TCM_OFS_CH1, 8'h00);
  idle(2);
  `CHK("ch1 no carrier", 1'b0, o_ch1_carrier)
  // unmapped places read zero and take no write
  wr_reg(12'h123, 8'hFF);
  rd_chk(12'h123, 8'h00);
  rd_chk(`TCM_OFS_RESTART, 8'h00);
  rd_chk(`TCM_OFS_CH0, 8'h70);
  // reset in mid-run clears both mode registers again
  wr_reg(`TCM_OFS_CH1, 8'h7E);
  idle(2);
  rst_seq(3);
  rd_chk(`TCM_OFS_CH0, 8'h00);
  rd_chk(`TCM_OFS_CH1, 8'h00);
  `CHK("ch1 running", 1'b0, o_ch1_running)
  end_sim();
end

endmodule // tb_tcm_top
`default_nettype wire
